/* File: shared/scd_defines.svh */
// offsets, field positions, reset values and timing counts of the command decoder
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
`define SCD_CLK_HZ 200000000
`define SCD_TICK_HZ 8
`define SCD_TICK_CYCLES (`SCD_CLK_HZ / `SCD_TICK_HZ)
`define SCD_RR_HOURS 32
`define SCD_RR_TICKS (`SCD_RR_HOURS * 3600 * `SCD_TICK_HZ)
`define SCD_HUNT_BITS 64
`define SCD_WORD_BITS 36
`define SCD_CHECK_BITS 7
`define SCD_SYNC_BITS 8
`define SCD_SYNC_PATTERN 8'hE5
`define SCD_CHECK_POLY 7'h09
`define SCD_ADDR_MSB 35
`define SCD_ADDR_LSB 31
`define SCD_KIND_MSB 30
`define SCD_KIND_LSB 29
`define SCD_STORE_BIT 28
`define SCD_PAY_MSB 27
`define SCD_PAY_LSB 7
`define SCD_MEM_BITS 2064
`define SCD_MEM_WORDS 86
`define SCD_START_CODE 21'h1FFFFF
`define SCD_OWN_ADDR 5'h05
`define SCD_REG_CTRL 12'h000
`define SCD_REG_STATUS 12'h004
`define SCD_REG_CLEAR 12'h008
`define SCD_REG_MEMCOUNT 12'h00C
`define SCD_REG_MEMREAD 12'h010
`define SCD_REG_ADDR 12'h014
`endif

/* File: shared/scd_pkg.sv */
// types shared by the command decoder
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_RT_OFF = 2'b00,
        SCD_RT_HUNT = 2'b01,
        SCD_RT_RECV = 2'b10
    } scd_rt_state_type;
    typedef enum logic [1:0] {
        SCD_SEQ_STOP = 2'b00,
        SCD_SEQ_WAIT_MAJOR = 2'b01,
        SCD_SEQ_FETCH = 2'b10,
        SCD_SEQ_DELAY = 2'b11
    } scd_seq_state_type;
    typedef enum logic [1:0] {
        SCD_KIND_PULSE = 2'b00,
        SCD_KIND_MAGNITUDE = 2'b01,
        SCD_KIND_DELAY = 2'b10,
        SCD_KIND_REVERSE = 2'b11
    } scd_kind_type;
endpackage : scd_pkg

/* File: design/scd_decoder.sv */
// central command decoder: uplink word processing, stored sequence processor, receiver reverse
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "scd_defines.svh"
module scd_decoder #(
    parameter int TICK_CYCLES = `SCD_TICK_CYCLES,
    parameter int RR_TICKS = `SCD_RR_TICKS,
    parameter int HUNT_BITS = `SCD_HUNT_BITS,
    parameter int MEM_WORDS = `SCD_MEM_WORDS
) (
    input wire logic mclk, // 200 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic link_clk, // demodulator bit clock
    input wire logic link_data, // demodulator data
    input wire logic link_lock, // demodulator in-lock
    input wire logic major_clk, // spacecraft major clock
    output logic rt_power, // real-time section on
    output logic out_valid, // word to remote decoder
    output logic [23:0] out_word, // kind and payload
    output logic [2:0] rr_pulse // receiver reverse pulses
);
    localparam int MEM_PTR_W = $clog2(MEM_WORDS + 1);
    localparam int MEM_WORD_W = `SCD_MEM_BITS / `SCD_MEM_WORDS;
    initial begin
        if (MEM_WORDS < 2 || MEM_WORDS > `SCD_MEM_WORDS || TICK_CYCLES < 2 || RR_TICKS < 2 || HUNT_BITS < 1
            || HUNT_BITS > 65536) begin
            $error("scd_decoder: unsupported parameter value");
        end
    end

    // pin synchronisers; third stage only feeds edge detection
    logic [1:0] clk_sync, dat_sync, lock_sync, maj_sync;
    logic clk_d, maj_d;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync <= 2'h0;
            dat_sync <= 2'h0;
            lock_sync <= 2'h0;
            maj_sync <= 2'h0;
            clk_d <= 1'b0;
            maj_d <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], link_clk};
            dat_sync <= {dat_sync[0], link_data};
            lock_sync <= {lock_sync[0], link_lock};
            maj_sync <= {maj_sync[0], major_clk};
            clk_d <= clk_sync[1];
            maj_d <= maj_sync[1];
        end
    end
    wire lock = lock_sync[1];
    wire bit_stb = clk_sync[1] & ~clk_d;
    wire bit_val = dat_sync[1];
    wire major_edge = maj_sync[1] & ~maj_d;

    // 8 Hz tick; 125 ms is exactly one tick, so it sets the issue spacing too
    logic [31:0] tick_div;
    wire tick = (tick_div == 32'(TICK_CYCLES - 1));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) tick_div <= 32'h0;
        else tick_div <= tick ? 32'h0 : tick_div + 32'h1;
    end

    function automatic logic [6:0] check_code(input logic [28:0] d);
        logic [6:0] r;
        logic fb;
        r = 7'h00;
        for (int i = 28; i >= 0; i--) begin
            fb = d[i] ^ r[6];
            r = {r[5:0], 1'b0} ^ (fb ? `SCD_CHECK_POLY : 7'h00);
        end
        return r;
    endfunction : check_code

    // registers read by software
    logic [4:0] own_addr;
    logic [1:0] rr_sel;
    logic reject_flag;
    logic [7:0] accept_cnt;

    // real-time word assembly
    scd_pkg::scd_rt_state_type rt_state, next_rt_state;
    logic [35:0] acc;
    logic [5:0] bit_cnt;
    logic [15:0] hunt_cnt;
    logic lock_d;
    wire [35:0] word_full = {acc[34:0], bit_val};
    wire sync_hit = ({acc[6:0], bit_val} == `SCD_SYNC_PATTERN);
    wire word_done = (rt_state == scd_pkg::SCD_RT_RECV) && bit_stb && (bit_cnt == 6'(`SCD_WORD_BITS - 1));
    wire addr_ok = (word_full[`SCD_ADDR_MSB:`SCD_ADDR_LSB] == own_addr);
    wire crc_ok = (check_code(word_full[35:7]) == word_full[6:0]);
    wire [1:0] kind = word_full[`SCD_KIND_MSB:`SCD_KIND_LSB];
    wire [20:0] payload = word_full[`SCD_PAY_MSB:`SCD_PAY_LSB];
    wire want_store = word_full[`SCD_STORE_BIT] && kind != scd_pkg::SCD_KIND_REVERSE;
    logic [MEM_PTR_W-1:0] mem_count;
    scd_pkg::scd_seq_state_type seq_state, next_seq_state;
    wire can_store = (mem_count < MEM_PTR_W'(MEM_WORDS)) && (seq_state == scd_pkg::SCD_SEQ_STOP);
    wire checked = word_done && addr_ok && crc_ok;
    wire accept = checked && (!want_store || can_store);
    wire reject = word_done && addr_ok && !accept;
    wire mem_wr = accept && want_store;
    wire rt_issue = accept && !want_store && (kind == scd_pkg::SCD_KIND_PULSE || kind == scd_pkg::SCD_KIND_MAGNITUDE)
        && payload != `SCD_START_CODE;
    wire start_cmd = accept && !want_store && kind == scd_pkg::SCD_KIND_PULSE && payload == `SCD_START_CODE;
    wire rr_cmd = accept && !want_store && kind == scd_pkg::SCD_KIND_REVERSE && payload[1:0] != 2'h3;
    // frozen count after first sync must never switch the section off again
    wire hunt_out = bit_stb && !synced && !sync_hit && hunt_cnt == 16'(HUNT_BITS - 1);

    always_comb begin
        next_rt_state = rt_state;
        case (rt_state)
            scd_pkg::SCD_RT_OFF: if (lock && !lock_d) next_rt_state = scd_pkg::SCD_RT_HUNT;
            scd_pkg::SCD_RT_HUNT: begin
                if (bit_stb && sync_hit) next_rt_state = scd_pkg::SCD_RT_RECV;
                else if (hunt_out) next_rt_state = scd_pkg::SCD_RT_OFF;
            end
            scd_pkg::SCD_RT_RECV: if (word_done) next_rt_state = scd_pkg::SCD_RT_HUNT;
            default: next_rt_state = scd_pkg::SCD_RT_OFF;
        endcase
        if (!lock) next_rt_state = scd_pkg::SCD_RT_OFF;
    end

    logic synced;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rt_state <= scd_pkg::SCD_RT_OFF;
            acc <= 36'h0;
            bit_cnt <= 6'h0;
            hunt_cnt <= 16'h0;
            lock_d <= 1'b0;
            synced <= 1'b0;
        end else begin
            rt_state <= next_rt_state;
            lock_d <= lock;
            if (rt_state == scd_pkg::SCD_RT_OFF) begin
                acc <= 36'h0;
                hunt_cnt <= 16'h0;
                synced <= 1'b0;
            end else if (bit_stb) begin
                acc <= (word_done && !addr_ok) || (rt_state == scd_pkg::SCD_RT_HUNT && sync_hit) ? 36'h0 : word_full;
                bit_cnt <= (rt_state == scd_pkg::SCD_RT_RECV) ? bit_cnt + 6'h1 : 6'h0;
                if (sync_hit) synced <= 1'b1;
                if (!synced) hunt_cnt <= hunt_cnt + 16'h1; // limit runs only from power-up to first sync
            end
        end
    end
    assign rt_power = (rt_state != scd_pkg::SCD_RT_OFF);

    // stored sequence memory: a rotating array stands in for the recirculating shift register
    logic [MEM_WORD_W-1:0] mem [MEM_WORDS];
    logic [MEM_PTR_W-1:0] mem_ptr;
    logic [15:0] delay_cnt;
    logic seq_pend;
    wire [MEM_WORD_W-1:0] head = mem[mem_ptr];
    wire step = seq_state == scd_pkg::SCD_SEQ_FETCH && seq_pend && !rt_issue;
    wire seq_end = step && mem_ptr == mem_count;
    wire seq_delay = step && !seq_end && head[23:22] == scd_pkg::SCD_KIND_DELAY;
    wire seq_issue = step && !seq_end && !seq_delay;

    // apb: one wait state, reply registered
    logic ack;
    wire acc_phase = psel && penable;
    wire hit_ctrl = paddr == `SCD_REG_CTRL;
    wire hit_status = paddr == `SCD_REG_STATUS;
    wire hit_clear = paddr == `SCD_REG_CLEAR;
    wire hit_count = paddr == `SCD_REG_MEMCOUNT;
    wire hit_read = paddr == `SCD_REG_MEMREAD;
    wire hit_addr = paddr == `SCD_REG_ADDR;
    wire addr_hit = hit_ctrl | hit_status | hit_clear | hit_count | hit_read | hit_addr;
    wire bus_wr = acc_phase && ack && pwrite;
    wire stopped = seq_state == scd_pkg::SCD_SEQ_STOP;
    wire readout = acc_phase && ack && !pwrite && hit_read && stopped && mem_count != '0;
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, rr_sel}
        : hit_status ? {8'h0, accept_cnt, 6'h0, rt_power, reject_flag, 4'h0, seq_state, rt_state}
        : hit_count ? 32'(mem_count)
        : hit_read ? (stopped ? 32'(head) : 32'h0)
        : hit_addr ? {27'h0, own_addr} : 32'h0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            prdata <= 32'h0;
        end else begin
            ack <= acc_phase && !ack;
            if (acc_phase && !ack) prdata <= rd_mux;
        end
    end
    assign pready = ack;
    assign pslverr = ack && !addr_hit;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            own_addr <= `SCD_OWN_ADDR;
            rr_sel <= 2'h0;
            reject_flag <= 1'b0;
            accept_cnt <= 8'h0;
        end else begin
            if (bus_wr && hit_addr) own_addr <= pwdata[4:0];
            if (bus_wr && hit_ctrl && pwdata[1:0] != 2'h3) rr_sel <= pwdata[1:0];
            if (rr_cmd) rr_sel <= payload[1:0];
            if (reject) reject_flag <= 1'b1; // set wins over clear
            else if (bus_wr && hit_clear && pwdata[0]) reject_flag <= 1'b0;
            if (rt_state == scd_pkg::SCD_RT_OFF) accept_cnt <= 8'h0;
            else if (accept && accept_cnt != 8'hFF) accept_cnt <= accept_cnt + 8'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (mem_wr) mem[mem_count] <= {kind, 1'b0, payload};
    end

    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            scd_pkg::SCD_SEQ_STOP: if (start_cmd) next_seq_state = scd_pkg::SCD_SEQ_WAIT_MAJOR;
            scd_pkg::SCD_SEQ_WAIT_MAJOR: if (major_edge) next_seq_state = scd_pkg::SCD_SEQ_FETCH;
            scd_pkg::SCD_SEQ_FETCH: begin
                if (seq_end) next_seq_state = scd_pkg::SCD_SEQ_STOP;
                else if (seq_delay) next_seq_state = scd_pkg::SCD_SEQ_DELAY;
            end
            scd_pkg::SCD_SEQ_DELAY: if (tick && delay_cnt == 16'h0) next_seq_state = scd_pkg::SCD_SEQ_FETCH;
            default: next_seq_state = scd_pkg::SCD_SEQ_STOP;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq_state <= scd_pkg::SCD_SEQ_STOP;
            mem_ptr <= '0;
            mem_count <= '0;
            delay_cnt <= 16'h0;
            seq_pend <= 1'b0;
        end else begin
            seq_state <= next_seq_state;
            if (mem_wr) mem_count <= mem_count + MEM_PTR_W'(1);
            if (seq_state == scd_pkg::SCD_SEQ_WAIT_MAJOR) begin
                mem_ptr <= '0; // leading word brought to the head
                seq_pend <= 1'b0;
            end else if (readout) begin
                mem_ptr <= (mem_ptr + MEM_PTR_W'(1) >= mem_count) ? '0 : mem_ptr + MEM_PTR_W'(1);
            end else if (seq_end) begin
                mem_ptr <= '0; // words remain in place for the next readout
            end else if (step) begin
                mem_ptr <= mem_ptr + MEM_PTR_W'(1);
            end
            if (seq_state == scd_pkg::SCD_SEQ_FETCH) begin
                if (step) seq_pend <= 1'b0;
                else if (tick) seq_pend <= 1'b1;
            end
            if (seq_delay) delay_cnt <= head[15:0];
            else if (seq_state == scd_pkg::SCD_SEQ_DELAY && tick && delay_cnt != 16'h0) delay_cnt <= delay_cnt - 16'h1;
        end
    end

    // output section and receiver reverse
    logic [31:0] rr_cnt;
    wire rr_expire = tick && rr_cnt == 32'(RR_TICKS - 1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_word <= 24'h0;
            rr_pulse <= 3'h0;
            rr_cnt <= 32'h0;
        end else begin
            out_valid <= rt_issue || seq_issue;
            if (rt_issue) out_word <= {kind, 1'b0, payload};
            else if (seq_issue) out_word <= head;
            rr_pulse <= 3'h0;
            if (rr_cmd) rr_pulse <= 3'h1 << payload[1:0];
            else if (rr_expire) rr_pulse <= 3'h1 << rr_sel;
            if (checked || rr_cmd || rr_expire) rr_cnt <= 32'h0;
            else if (tick) rr_cnt <= rr_cnt + 32'h1;
        end
    end

    a_lock_gates_power: assert property (@(posedge mclk) disable iff (!rst_n) !lock |=> !rt_power)
        else $error("real-time section on without lock");
    a_hunt_timeout: assert property (@(posedge mclk) disable iff (!rst_n)
        rt_state == scd_pkg::SCD_RT_HUNT && !synced && hunt_out |=> !rt_power)
        else $error("hunt limit did not switch section off");
    a_addr_clears: assert property (@(posedge mclk) disable iff (!rst_n)
        word_done && !addr_ok && lock |=> acc == 36'h0 && out_valid == $past(seq_issue))
        else $error("foreign word not cleared");
    a_reject_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        reject |=> reject_flag ##1 (reject_flag || $past(bus_wr && hit_clear && pwdata[0])))
        else $error("reject flag not held");
    a_accept_count: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && accept_cnt != 8'hFF && lock |=> accept_cnt == $past(accept_cnt) + 8'h1)
        else $error("accepted count wrong");
    a_store_grows: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_wr |=> mem_count == $past(mem_count) + MEM_PTR_W'(1) && !out_valid)
        else $error("stored word not appended");
    a_start_major: assert property (@(posedge mclk) disable iff (!rst_n)
        seq_state == scd_pkg::SCD_SEQ_WAIT_MAJOR && !major_edge |=> seq_state == scd_pkg::SCD_SEQ_WAIT_MAJOR)
        else $error("sequencer left wait without major edge");
    a_delay_halts: assert property (@(posedge mclk) disable iff (!rst_n)
        seq_state == scd_pkg::SCD_SEQ_DELAY && !(tick && delay_cnt == 16'h0)
        |=> seq_state == scd_pkg::SCD_SEQ_DELAY && !seq_issue)
        else $error("stored word issued during delay");
    a_rr_restart: assert property (@(posedge mclk) disable iff (!rst_n) checked |=> rr_cnt == 32'h0)
        else $error("reverse timer not restarted");
    a_rr_onehot: assert property (@(posedge mclk) disable iff (!rst_n) $onehot0(rr_pulse))
        else $error("more than one reverse pulse");
    c_sync_found: cover property (@(posedge mclk) disable iff (!rst_n) bit_stb && sync_hit && rt_state == scd_pkg::SCD_RT_HUNT);
    c_accept: cover property (@(posedge mclk) disable iff (!rst_n) accept);
    c_stored_issue: cover property (@(posedge mclk) disable iff (!rst_n) seq_issue);
    c_rr_expire: cover property (@(posedge mclk) disable iff (!rst_n) rr_expire);
endmodule : scd_decoder

/* File: testbench/scd_demod_model.sv */
// demodulator stand-in: in-lock level, regenerated bit clock and serial data
`timescale 1ns/100ps
module scd_demod_model (
    output logic link_clk, // bit clock, still between frames
    output logic link_data, // serial data, msb first
    output logic link_lock // in-lock level
);
    initial begin
        link_clk = 1'b0;
        link_data = 1'b1;
        link_lock = 1'b0;
    end
    task automatic set_lock(input logic v);
        link_lock <= v;
    endtask : set_lock
    // 80 ns bit period; odd start offset keeps the link out of phase with mclk
    task automatic send(input logic [63:0] bits, input int n);
        #1.3;
        for (int i = n - 1; i >= 0; i--) begin
            link_data = bits[i];
            #20 link_clk = 1'b1;
            #40 link_clk = 1'b0;
            #20;
        end
        // released line flips so a stale bit can never pass for a fresh one
        link_data = ~link_data;
    endtask : send
endmodule : scd_demod_model

/* File: testbench/scd_decoder_tb.sv */
// self-checking bench of the central command decoder
`timescale 1ns/100ps
`include "scd_defines.svh"
module scd_decoder_tb;
    localparam int TICK = 20;
    localparam int RR = 100;
    logic mclk, rst_n, psel, penable, pwrite, major_clk, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic link_clk, link_data, link_lock, rt_power, out_valid;
    logic [23:0] out_word;
    logic [2:0] rr_pulse, rr_last;
    logic [23:0] ov_q[$];
    int ov_at[$];
    int errors, cmp_count, rr_cnt, t0, n;
    int cyc = 0;
    scd_decoder #(.TICK_CYCLES(TICK), .RR_TICKS(RR), .HUNT_BITS(64), .MEM_WORDS(86)) scd_decoder_inst (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .link_data(link_data), .link_lock(link_lock), .major_clk(major_clk), .rt_power(rt_power),
        .out_valid(out_valid), .out_word(out_word), .rr_pulse(rr_pulse));
    scd_demod_model scd_demod_model_inst (.link_clk(link_clk), .link_data(link_data), .link_lock(link_lock));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // one-cycle pulses are caught in the cycle they stand
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1) begin
            ov_q.push_back(out_word);
            ov_at.push_back(cyc);
        end
        if (|rr_pulse === 1'b1) begin
            rr_cnt++;
            rr_last = rr_pulse;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a stalled wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    function automatic logic [35:0] mk(input logic [4:0] a, input logic [1:0] k, input logic s, input logic [20:0] p);
        logic [28:0] m;
        logic [6:0] c;
        m = {a, k, s, p};
        c = 7'h00;
        for (int i = 28; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? `SCD_CHECK_POLY : 7'h00);
        return {m, c};
    endfunction : mk
    task automatic sendw(input logic [35:0] w);
        // zero preamble keeps the tail of the last word from faking a sync
        scd_demod_model_inst.send({20'h00000, `SCD_SYNC_PATTERN, w}, 64);
        repeat (2) @(posedge mclk);
    endtask : sendw
    task automatic t_reset;
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        apb(1'b0, `SCD_REG_ADDR, 32'h0);
        chk("own_addr", rd, 32'h5);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped_err", 32'(err), 32'h1);
    endtask : t_reset
    task automatic t_hunt;
        scd_demod_model_inst.set_lock(1'b1);
        repeat (6) @(posedge mclk);
        chk("power_on", 32'(rt_power), 32'h1);
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("hunting", 32'(rd[1:0]), 32'h1);
        scd_demod_model_inst.send(64'h0, 63);
        chk("on_at_63", 32'(rt_power), 32'h1);
        scd_demod_model_inst.send(64'h0, 1);
        chk("off_at_64", 32'(rt_power), 32'h0);
        scd_demod_model_inst.set_lock(1'b0);
        repeat (6) @(posedge mclk);
        scd_demod_model_inst.set_lock(1'b1);
        repeat (6) @(posedge mclk);
    endtask : t_hunt
    task automatic t_realtime;
        ov_q.delete();
        sendw(mk(`SCD_OWN_ADDR, 2'd0, 1'b0, 21'h00ABC));
        chk("rt_out_count", 32'(ov_q.size()), 32'h1);
        chk("rt_out_word", 32'(ov_q[0]), 32'h000ABC);
        sendw(mk(5'h06, 2'd0, 1'b0, 21'h00ABC));
        chk("foreign_count", 32'(ov_q.size()), 32'h1);
        sendw(mk(`SCD_OWN_ADDR, 2'd1, 1'b0, 21'h000100) ^ 36'h000000100);
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("flag_single", 32'(rd[8]), 32'h1);
        apb(1'b1, `SCD_REG_CLEAR, 32'h1);
        sendw(mk(`SCD_OWN_ADDR, 2'd1, 1'b0, 21'h000100) ^ 36'h000010001);
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("flag_double", 32'(rd[8]), 32'h1);
        chk("accept_count", 32'(rd[23:16]), 32'h1);
        chk("bad_no_out", 32'(ov_q.size()), 32'h1);
        apb(1'b1, `SCD_REG_CLEAR, 32'h1);
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("flag_clear", 32'(rd[8]), 32'h0);
    endtask : t_realtime
    task automatic t_stored;
        ov_q.delete();
        ov_at.delete();
        sendw(mk(`SCD_OWN_ADDR, 2'd2, 1'b1, 21'd2));
        sendw(mk(`SCD_OWN_ADDR, 2'd0, 1'b1, 21'h000123));
        sendw(mk(`SCD_OWN_ADDR, 2'd1, 1'b1, 21'h004567));
        chk("stored_no_out", 32'(ov_q.size()), 32'h0);
        apb(1'b0, `SCD_REG_MEMCOUNT, 32'h0);
        chk("mem_count", rd, 32'h3);
        apb(1'b0, `SCD_REG_MEMREAD, 32'h0);
        chk("read_delay", rd, 32'h00800002);
        apb(1'b0, `SCD_REG_MEMREAD, 32'h0);
        chk("read_pulse", rd, 32'h00000123);
        apb(1'b0, `SCD_REG_MEMREAD, 32'h0);
        chk("read_mag", rd, 32'h00404567);
        apb(1'b0, `SCD_REG_MEMREAD, 32'h0);
        chk("read_wrap", rd, 32'h00800002);
        apb(1'b0, `SCD_REG_MEMCOUNT, 32'h0);
        chk("kept_count", rd, 32'h3);
        sendw(mk(`SCD_OWN_ADDR, 2'd0, 1'b0, `SCD_START_CODE));
        ov_q.delete();
        ov_at.delete();
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("wait_major", 32'(rd[3:2]), 32'h1);
        apb(1'b0, `SCD_REG_MEMREAD, 32'h0);
        chk("read_running", rd, 32'h0);
        repeat (60) @(posedge mclk);
        chk("held_major", 32'(ov_q.size()), 32'h0);
        major_clk <= 1'b1;
        t0 = cyc;
        repeat (4) @(posedge mclk);
        major_clk <= 1'b0;
        n = 0;
        while (ov_q.size() < 2 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk("seq_count", 32'(ov_q.size()), 32'h2);
        chk("seq_pulse", 32'(ov_q[0]), 32'h000123);
        chk("seq_mag", 32'(ov_q[1]), 32'h404567);
        chk("after_delay", 32'(ov_at[0] - t0 >= 4 * TICK), 32'h1);
        chk("delay_bound", 32'(ov_at[0] - t0 < 6 * TICK), 32'h1);
        chk("word_spacing", 32'(ov_at[1] - ov_at[0] >= TICK), 32'h1);
        repeat (3 * TICK) @(posedge mclk);
        apb(1'b0, `SCD_REG_STATUS, 32'h0);
        chk("seq_stopped", 32'(rd[3:2]), 32'h0);
    endtask : t_stored
    task automatic t_reverse;
        for (int k = 0; k < 3; k++) begin
            rr_cnt = 0;
            sendw(mk(`SCD_OWN_ADDR, 2'd3, 1'b0, 21'(k)));
            chk("rr_cmd_count", 32'(rr_cnt), 32'h1);
            chk("rr_cmd_line", 32'(rr_last), 32'(3'b001 << k));
        end
        apb(1'b1, `SCD_REG_CTRL, 32'h1);
        apb(1'b1, `SCD_REG_CTRL, 32'h3);
        apb(1'b0, `SCD_REG_CTRL, 32'h0);
        chk("ctrl_sel", rd, 32'h1);
        rr_cnt = 0;
        repeat (RR * TICK - 100) @(posedge mclk);
        chk("rr_restarted", 32'(rr_cnt), 32'h0);
        n = 0;
        while (rr_cnt == 0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk("rr_timer_line", 32'(rr_last), 32'h2);
    endtask : t_reverse
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        major_clk = 1'b0;
        errors = 0;
        cmp_count = 0;
        rr_cnt = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_hunt;
        t_realtime;
        t_stored;
        t_reverse;
        give_verdict;
    end
    // the full run needs roughly 15k cycles; this cuts a hang well after that
    initial begin
        #300000;
        errors++;
        give_verdict;
    end
endmodule : scd_decoder_tb
